// >>> design/acc_cfg.svh
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define ACC_OFS_CTRL_A 8'h00
`define ACC_OFS_CTRL_B 8'h04
`define ACC_OFS_PIN_FN 8'h08
`define ACC_OFS_STAT 8'h0c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACC_A_START 7
`define ACC_A_BUSY 6
`define ACC_A_PWR 5
`define ACC_A_FMT 4
`define ACC_B_SRC_LSB 5
`define ACC_B_REF_LSB 3
`define ACC_ST_FLAG 0
`define ACC_ST_IEN 1

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define ACC_RST_CTRL_A 8'h00
`define ACC_RST_CTRL_B 8'h00
`define ACC_RST_PIN_FN 10'h000
`define ACC_SRC_BANDGAP 3'h1
`define ACC_SRC_AMP_FIRST 3'h2
`define ACC_SRC_AMP_SECOND 3'h3
`define ACC_SRC_VSS 3'h4
`define ACC_REF_VDD 2'h1
`define ACC_NUM_PINS 10
`define ACC_RESULT_BITS 12

// ---------------------------------------------------------------
// Timing in converter clock periods
// ---------------------------------------------------------------
`define ACC_SAMPLE_PER 4'd4
`define ACC_CONV_PER 4'd12
`define ACC_TOTAL_PER 16

`endif

// >>> design/acc_pkg.sv
package acc_pkg;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'h1,
        ACC_SAMPLE = 3'h2,
        ACC_CONVERT = 3'h4
    } acc_state_e;
    typedef logic [2:0] acc_div_t;
endpackage : acc_pkg

// >>> design/acc_div_if.sv
`timescale 1ns/1ps
interface acc_div_if;
    acc_pkg::acc_div_t sel;
    logic clr;
    logic run;
    logic tick;
    modport ctrl (output sel, output clr, output run, input tick);
    modport div (input sel, input clr, input run, output tick);
endinterface : acc_div_if

// >>> design/acc_clk_div.sv
`timescale 1ns/1ps
module acc_clk_div #(
    parameter int CNT_W = 7
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    acc_div_if.div dif
);
    logic [CNT_W-1:0] cnt_q;
    wire [CNT_W-1:0] mask_w = ~({CNT_W{1'b1}} << dif.sel);

    initial begin
        if (CNT_W != 7) $error("acc_clk_div needs a 7-bit counter for divide by 128");
    end

    // Tick once every 2^sel system clocks
    assign dif.tick = dif.run & (cnt_q == mask_w);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            if (dif.clr || !dif.run || dif.tick) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule : acc_clk_div

// >>> design/acc_conv_ctrl.sv
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_conv_ctrl #(
    parameter int NUM_PINS = `ACC_NUM_PINS,
    parameter int DIV_W = 3
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    output logic power_en_o,
    output logic conv_tick_o,
    output logic sample_o,
    output logic convert_o,
    output logic eoc_o,
    output logic irq_o,
    output logic ref_vdd_o,
    output logic ref_ext_o,
    output logic [NUM_PINS-1:0] ext_pin_sel_o,
    output logic [3:0] int_src_sel_o,
    output logic [NUM_PINS-1:0] pin_analog_o
);
    initial begin
        if (NUM_PINS != 10) $error("acc_conv_ctrl serves exactly ten pin slots");
        if (DIV_W != 3) $error("acc_conv_ctrl needs a 3-bit divider select");
    end

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;
    wire rstn = rst_sync_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic hready_q;
    logic [31:0] hrdata_q;
    wire [31:0] rdata_w;

    wire addr_ok = hsel_i & hready_i & htrans_i[1];
    wire hit_a = addr_q == `ACC_OFS_CTRL_A;
    wire hit_b = addr_q == `ACC_OFS_CTRL_B;
    wire hit_p = addr_q == `ACC_OFS_PIN_FN;
    wire hit_s = addr_q == `ACC_OFS_STAT;
    wire wr_a = wr_pend_q & hit_a;
    wire wr_b = wr_pend_q & hit_b;
    wire wr_p = wr_pend_q & hit_p;
    wire wr_s = wr_pend_q & hit_s;

    // Reads take one wait state so a write just before is visible
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            hready_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            wr_pend_q <= addr_ok & hwrite_i;
            rd_pend_q <= addr_ok & ~hwrite_i;
            if (addr_ok) begin
                addr_q <= haddr_i[7:0];
            end
            hready_q <= ~(addr_ok & ~hwrite_i);
            if (rd_pend_q) begin
                hrdata_q <= rdata_w;
            end
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    logic start_q;
    logic pwr_q;
    logic fmt_q;
    logic [3:0] chan_q;
    logic [2:0] src_q;
    logic [1:0] ref_q;
    acc_pkg::acc_div_t div_q;
    logic [NUM_PINS-1:0] pin_q;
    logic ien_q;
    logic flag_q;
    localparam logic [7:0] RST_A = `ACC_RST_CTRL_A;

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            start_q <= RST_A[`ACC_A_START];
            pwr_q <= RST_A[`ACC_A_PWR];
            fmt_q <= RST_A[`ACC_A_FMT];
            chan_q <= RST_A[3:0];
            {src_q, ref_q, div_q} <= `ACC_RST_CTRL_B;
            pin_q <= `ACC_RST_PIN_FN;
            ien_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_a) begin
                start_q <= hwdata_i[`ACC_A_START];
                pwr_q <= hwdata_i[`ACC_A_PWR];
                fmt_q <= hwdata_i[`ACC_A_FMT];
                chan_q <= hwdata_i[3:0];
            end
            if (wr_b) begin
                {src_q, ref_q, div_q} <= hwdata_i[7:0];
            end
            if (wr_p) begin
                pin_q <= hwdata_i[NUM_PINS-1:0];
            end
            if (wr_s) begin
                ien_q <= hwdata_i[`ACC_ST_IEN];
            end
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    acc_pkg::acc_state_e state_q;
    acc_pkg::acc_state_e state_d;
    logic [3:0] per_q;
    logic [3:0] per_d;
    acc_div_if dif ();

    wire start_fall = wr_a & start_q & ~hwdata_i[`ACC_A_START];
    wire launch = start_fall & hwdata_i[`ACC_A_PWR];
    wire busy = state_q != acc_pkg::ACC_IDLE;
    wire tick = dif.tick;
    wire last_sample = per_q == `ACC_SAMPLE_PER - 4'd1;
    wire last_conv = per_q == `ACC_CONV_PER - 4'd1;
    wire done_w = (state_q == acc_pkg::ACC_CONVERT) & tick & last_conv & pwr_q & ~launch;

    assign dif.sel = div_q;
    assign dif.clr = launch;
    assign dif.run = pwr_q & busy;

    acc_clk_div #(
        .CNT_W(7)
    ) u_div (
        .clk_i(clk_i),
        .rstn_i(rstn),
        .ce_i(ce_i),
        .dif(dif)
    );

    always_comb begin
        state_d = state_q;
        per_d = per_q;
        if (launch) begin
            state_d = acc_pkg::ACC_SAMPLE;
            per_d = 4'd0;
        end else if (!pwr_q) begin
            state_d = acc_pkg::ACC_IDLE;
            per_d = 4'd0;
        end else if (tick) begin
            case (state_q)
                acc_pkg::ACC_SAMPLE: begin
                    per_d = last_sample ? 4'd0 : per_q + 4'd1;
                    if (last_sample) begin
                        state_d = acc_pkg::ACC_CONVERT;
                    end
                end
                acc_pkg::ACC_CONVERT: begin
                    per_d = last_conv ? 4'd0 : per_q + 4'd1;
                    if (last_conv) begin
                        state_d = acc_pkg::ACC_IDLE;
                    end
                end
                default: begin
                    state_d = acc_pkg::ACC_IDLE;
                    per_d = 4'd0;
                end
            endcase
        end
    end

    wire flag_d = done_w | (flag_q & ~(wr_s & hwdata_i[`ACC_ST_FLAG]));

    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            state_q <= acc_pkg::ACC_IDLE;
            per_q <= 4'd0;
            flag_q <= 1'b0;
        end else if (ce_i) begin
            state_q <= state_d;
            per_q <= per_d;
            flag_q <= flag_d;
        end
    end

    // ---------------------------------------------------------------
    // Analog routing decode
    // ---------------------------------------------------------------
    wire ext_src = ~((src_q >= `ACC_SRC_BANDGAP) & (src_q <= `ACC_SRC_VSS));
    wire ref_vdd_w = ref_q == `ACC_REF_VDD;
    wire [3:0] int_sel_w = {src_q == `ACC_SRC_VSS, src_q == `ACC_SRC_AMP_SECOND,
                            src_q == `ACC_SRC_AMP_FIRST, src_q == `ACC_SRC_BANDGAP};
    wire [NUM_PINS-1:0] pin_sel_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            // Slot 7 has no pin; codes 10 and up hit no slot
            assign pin_sel_w[gi] = ext_src & (chan_q == 4'(gi)) & (gi != 7);
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    wire [31:0] rd_a = {24'h00_0000, start_q, busy, pwr_q, fmt_q, chan_q};
    wire [31:0] rd_b = {24'h00_0000, src_q, ref_q, div_q};
    wire [31:0] rd_p = {{(32 - NUM_PINS){1'b0}}, pin_q};
    wire [31:0] rd_s = {30'h0000_0000, ien_q, flag_q};
    assign rdata_w = hit_a ? rd_a : hit_b ? rd_b : hit_p ? rd_p : hit_s ? rd_s : 32'h0;

    // ---------------------------------------------------------------
    // Output registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            power_en_o <= 1'b0;
            conv_tick_o <= 1'b0;
            sample_o <= 1'b0;
            convert_o <= 1'b0;
            eoc_o <= 1'b0;
            irq_o <= 1'b0;
            ref_vdd_o <= 1'b0;
            ref_ext_o <= 1'b1;
            ext_pin_sel_o <= '0;
            int_src_sel_o <= 4'h0;
            pin_analog_o <= '0;
        end else if (ce_i) begin
            power_en_o <= pwr_q;
            conv_tick_o <= tick;
            sample_o <= state_q == acc_pkg::ACC_SAMPLE;
            convert_o <= state_q == acc_pkg::ACC_CONVERT;
            eoc_o <= done_w;
            irq_o <= flag_q & ien_q;
            ref_vdd_o <= ref_vdd_w;
            ref_ext_o <= ~ref_vdd_w;
            ext_pin_sel_o <= pin_sel_w;
            int_src_sel_o <= int_sel_w;
            pin_analog_o <= pin_q;
        end
    end

    assign hreadyout_o = hready_q;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [11:0] cyc_q;
    always_ff @(posedge clk_i or negedge rstn) begin
        if (!rstn) begin
            cyc_q <= 12'h000;
        end else if (ce_i) begin
            cyc_q <= launch ? 12'h000 : busy ? cyc_q + 12'h001 : cyc_q;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn);

    property p_launch_busy;
        launch && ce_i |=> busy && per_q == 4'd0 ##1 (!ce_i || sample_o);
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("busy not set on launch");

    property p_rise_idle;
        wr_a && !busy && hwdata_i[`ACC_A_START] && ce_i |=> !busy;
    endproperty
    a_rise_idle: assert property (p_rise_idle) else $error("rising start launched");

    property p_len;
        done_w |-> cyc_q == 12'((`ACC_TOTAL_PER << div_q) - 1);
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");

    property p_done_idle;
        done_w && ce_i |=> !busy ##1 (!ce_i || eoc_o == 1'b0);
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("busy kept after end");

    property p_flag;
        done_w && ce_i |=> flag_q && eoc_o;
    endproperty
    a_flag: assert property (p_flag) else $error("request flag not set");

    property p_irq;
        flag_q && ien_q && ce_i |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_abort;
        busy && !pwr_q && !launch && !wr_s && ce_i |=> !busy && flag_q == $past(flag_q);
    endproperty
    a_abort: assert property (p_abort) else $error("abort handled wrong");

    property p_off;
        !pwr_q && !wr_a && ce_i |=> !busy;
    endproperty
    a_off: assert property (p_off) else $error("conversion without power");

    property p_ref;
        ce_i |=> ref_vdd_o == ($past(ref_q) == `ACC_REF_VDD) && ref_ext_o == !ref_vdd_o;
    endproperty
    a_ref: assert property (p_ref) else $error("reference routing wrong");

    property p_pins;
        ce_i |=> $onehot0(ext_pin_sel_o) && ((ext_pin_sel_o != '0) == ($past(ext_src)
            && ($past(chan_q) <= 4'h6 || $past(chan_q) == 4'h8 || $past(chan_q) == 4'h9)));
    endproperty
    a_pins: assert property (p_pins) else $error("pin routing wrong");

    property p_int;
        ce_i |=> (int_src_sel_o != 4'h0) == !$past(ext_src) && $onehot0(int_src_sel_o);
    endproperty
    a_int: assert property (p_int) else $error("internal routing wrong");

    c_done: cover property (done_w);
    c_abort: cover property (busy && !pwr_q);
    c_irq: cover property (irq_o);
    c_restart: cover property (busy && launch);
    c_launch: cover property (launch);
endmodule : acc_conv_ctrl

// >>> tb/acc_core_model.sv
`timescale 1ns/1ps
module acc_core_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic clr_i,
    input wire logic power_en_i,
    input wire logic conv_tick_i,
    input wire logic sample_i,
    input wire logic convert_i,
    input wire logic eoc_i,
    output int tick_n_o,
    output int samp_n_o,
    output int conv_n_o,
    output int done_n_o,
    output int dead_n_o
);
    // ---------------------------------------------------------------
    // Analog core activity counters
    // ---------------------------------------------------------------
    logic pw_q;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i || clr_i) begin
            tick_n_o <= 0;
            samp_n_o <= 0;
            conv_n_o <= 0;
            done_n_o <= 0;
            pw_q <= 1'b0;
        end else begin
            pw_q <= power_en_i;
            tick_n_o <= tick_n_o + int'(conv_tick_i);
            samp_n_o <= samp_n_o + int'(sample_i);
            conv_n_o <= conv_n_o + int'(convert_i);
            done_n_o <= done_n_o + int'(eoc_i);
        end
    end

    // Core must not run unpowered; one cycle of grace for the abort
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dead_n_o <= 0;
        end else if (!power_en_i && !pw_q && (sample_i || convert_i)) begin
            dead_n_o <= dead_n_o + 1;
        end
    end
endmodule : acc_core_model

// >>> tb/tb_adc_conversion_control.sv
`timescale 1ns/1ps
module tb_adc_conversion_control;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic clr = 1'b0;
    logic hreadyout, hresp, power_en, conv_tick, sample, convert, eoc, irq, ref_vdd, ref_ext;
    logic [9:0] ext_pin_sel;
    logic [9:0] pin_analog;
    logic [3:0] int_src_sel;
    logic [31:0] hrdata;
    int tick_n, samp_n, conv_n, done_n, dead_n;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic rd_on = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h0fa2;

    always #25 clk = ~clk;

    acc_conv_ctrl dut (.clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .hrdata_o(hrdata), .power_en_o(power_en),
        .conv_tick_o(conv_tick), .sample_o(sample), .convert_o(convert), .eoc_o(eoc),
        .irq_o(irq), .ref_vdd_o(ref_vdd), .ref_ext_o(ref_ext),
        .ext_pin_sel_o(ext_pin_sel), .int_src_sel_o(int_src_sel), .pin_analog_o(pin_analog));

    acc_core_model core (.clk_i(clk), .rstn_i(rstn), .clr_i(clr), .power_en_i(power_en),
        .conv_tick_i(conv_tick), .sample_i(sample), .convert_i(convert), .eoc_i(eoc),
        .tick_n_o(tick_n), .samp_n_o(samp_n), .conv_n_o(conv_n), .done_n_o(done_n),
        .dead_n_o(dead_n));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // One AHB-Lite single word transfer; a read notes its expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (!wr) exp_q.push_back(d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : ~d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic convert_once(input logic [2:0] dv, input logic ie);
        bus(1'b1, 8'h04, {29'h0, dv});
        bus(1'b1, 8'h0c, {30'h0, ie, 1'b1});
        bus(1'b1, 8'h00, 32'h20);
        cyc(10);
        clr <= 1'b1;
        bus(1'b1, 8'h00, 32'ha0);
        clr <= 1'b0;
        bus(1'b0, 8'h00, 32'ha0);
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b0, 8'h00, 32'h60);
        repeat (2100) begin
            @(posedge clk);
            if (eoc === 1'b1) break;
        end
        cyc(2);
        chk("ticks", 32'd16, tick_n);
        chk("sample cycles", 32'd4 << dv, samp_n);
        chk("convert cycles", 32'd12 << dv, conv_n);
        chk("eoc pulses", 32'd1, done_n);
        chk("irq", {31'h0, ie}, {31'h0, irq});
        chk("power_en", 32'h1, {31'h0, power_en});
        bus(1'b0, 8'h00, 32'h20);
        bus(1'b0, 8'h0c, {30'h0, ie, 1'b1});
    endtask : convert_once

    // ---------------------------------------------------------------
    // Read monitor and timeout
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (rd_on && hreadyout === 1'b1) begin
            rd_on = 1'b0;
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("MISMATCH hrdata expected queued value seen none");
            end else begin
                chk("hrdata", exp_q.pop_front(), hrdata);
                chk("hresp", 32'h0, {31'h0, hresp});
            end
        end
        if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) rd_on = 1'b1;
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic ext;
        logic [31:0] cb;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        cyc(3);
        chk("ref_ext", 32'h1, {31'h0, ref_ext});
        for (int a = 0; a < 20; a += 4) bus(1'b0, a[7:0], 32'h0);
        bus(1'b1, 8'h10, 32'hffff_ffff);
        bus(1'b0, 8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'h40);
        bus(1'b0, 8'h00, 32'h0);
        for (int s = 0; s < 8; s++) begin
            seed = xs(seed);
            bus(1'b1, 8'h08, {22'h0, seed[9:0]});
            bus(1'b0, 8'h08, {22'h0, seed[9:0]});
            chk("pin_analog", {22'h0, seed[9:0]}, {22'h0, pin_analog});
            for (int c = 0; c < 16; c++) begin
                ext = (s == 0 || s > 4);
                if (!ext && c < 10) continue;
                cb = {24'h0, s[2:0], s[1:0], seed[12:10]};
                if (ext) bus(1'b1, 8'h04, cb);
                bus(1'b1, 8'h00, {28'h0, c[3:0]});
                if (!ext) bus(1'b1, 8'h04, cb);
                bus(1'b0, 8'h04, cb);
                chk("ref_vdd", {31'h0, s[1:0] == 2'h1}, {31'h0, ref_vdd});
                chk("ref_ext", {31'h0, s[1:0] != 2'h1}, {31'h0, ref_ext});
                chk("ext_pin_sel", (ext && c != 7 && c < 10) ? 32'h1 << c : 32'h0,
                    {22'h0, ext_pin_sel});
                chk("int_src_sel", ext ? 32'h0 : 32'h1 << (s - 1), {28'h0, int_src_sel});
            end
        end
        for (int d = 0; d < 8; d++) convert_once(d[2:0], d[0]);
        bus(1'b1, 8'h0c, 32'h1);
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b1, 8'h00, 32'ha0);
        bus(1'b1, 8'h00, 32'h20);
        cyc(20);
        bus(1'b1, 8'h00, 32'ha0);
        bus(1'b1, 8'h00, 32'h20);
        bus(1'b1, 8'h00, 32'h0);
        cyc(300);
        bus(1'b0, 8'h00, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        clr <= 1'b1;
        bus(1'b1, 8'h00, 32'h80);
        clr <= 1'b0;
        bus(1'b1, 8'h00, 32'h0);
        cyc(300);
        chk("ticks unpowered", 32'h0, tick_n);
        chk("eoc unpowered", 32'h0, done_n);
        chk("power_en off", 32'h0, {31'h0, power_en});
        bus(1'b1, 8'h0c, 32'h1);
        bus(1'b0, 8'h0c, 32'h0);
        chk("core unpowered activity", 32'h0, dead_n);
        close_out();
    end
endmodule : tb_adc_conversion_control
